// ---- design/srcp_pkg.sv ----
package srcp_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int BAUD_DEF = 9600;
   localparam logic [15:0] BAUD_DIV_DEF = 16'(CLK_HZ / BAUD_DEF);
   localparam int PUSH_TOUT_MS = 100;
   localparam int PUSH_TOUT_CYC = CLK_HZ / 1000 * PUSH_TOUT_MS;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_BAUD = 8'h04;
   localparam logic [7:0] A_FMT = 8'h08;
   localparam logic [7:0] A_JSEL = 8'h0C;
   localparam logic [7:0] A_JRES = 8'h10;
   localparam logic [7:0] A_PUSH = 8'h14;
   localparam logic [7:0] A_TOUT = 8'h18;
   localparam logic [7:0] A_STAT = 8'h1C;
   localparam logic [7:0] A_GO = 8'h20;
   localparam logic [7:0] A_VAL = 8'h30;
   localparam logic [7:0] A_VAL_END = 8'h3C;
   // Field positions and reset values
   localparam int C_PUSH = 0;
   localparam int C_PAR = 1;
   localparam int C_EIGHT = 3;
   localparam int C_TWO = 4;
   localparam int F_DWORD = 8;
   localparam int S_TOUT = 2;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;
   localparam logic [31:0] CTRL_RST = 32'h0000_0004;
   localparam logic [31:0] FMT_RST = 32'h0000_0015;
   localparam logic [31:0] PUSH_RST = 32'h0000_0000;
   // Characters and command codes
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_MINUS = 8'h2D;
   localparam logic [15:0] PFX_RES = 16'h5430;
   localparam logic [15:0] CMD_T1 = 16'h5431;
   localparam logic [15:0] CMD_T2 = 16'h5432;
   localparam logic [15:0] CMD_PG = 16'h5047;
   localparam logic [15:0] CMD_RN = 16'h524E;
   localparam logic [15:0] CMD_TO = 16'h544F;
   localparam logic [15:0] CMD_TF = 16'h5446;
   localparam logic [15:0] CMD_SV = 16'h5356;
   localparam logic [23:0] ERR_PERM = 24'h453031;
   localparam logic [23:0] ERR_FORM = 24'h453032;
   localparam logic [15:0] DONE_VAL = 16'h0001;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01, ST_REPLY = 6'h02, ST_INSP = 6'h04,
      ST_RESULT = 6'h08, ST_PUSH = 6'h10, ST_PACK = 6'h20
   } srcp_state_t;
   typedef struct packed {
      logic two_stop;
      logic eight;
      logic [1:0] parity;
   } srcp_line_t;
endpackage : srcp_pkg

// ---- design/srcp_port.sv ----
module srcp_port import srcp_pkg::*; #(
   parameter logic [31:0] TOUT_RST = 32'(PUSH_TOUT_CYC)
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   output logic txd,
   output logic [1:0] insp_req,
   input wire logic insp_done,
   output logic save_req,
   output logic run_state,
   output logic trig_enable
);
   typedef struct packed {
      srcp_state_t st;
      logic [31:0] ctrl, baud, fmt, jsel, jres, pcfg, tout, prd;
      logic [3:0][31:0] val;
      logic go_pend, run, trig_en, tout_err, save_p, pfx;
      logic [1:0] insp_p, src;
      logic [23:0] rep;
      logic [1:0] rep_n;
      logic [2:0] rep_i;
      logic [1:0] phase, bi;
      logic [2:0] vi;
      logic [3:0] ci, wi, fi;
      logic [31:0] tcnt;
      logic tx_busy;
      logic [15:0] tx_cnt, rx_cnt;
      logic [3:0] tx_bit, tx_nb, rx_bit;
      logic [11:0] tx_sh;
      logic rx_s1, rx_s2, rx_busy;
      logic [9:0] rx_sh;
      logic [15:0] cmd;
      logic [3:0] cmd_n;
      logic cmd_rdy;
   } srcp_regs_t;

   srcp_regs_t s, n;
   logic ch_v, take, rx_got;
   logic [7:0] ch, rx_ch;

   // Binary to ten BCD digits by shift and add
   function automatic logic [39:0] to_bcd(input logic [31:0] b);
      logic [39:0] d;
      d = '0;
      for (int i = 31; i >= 0; i--) begin
         for (int k = 0; k < 10; k++) begin
            if (d[k*4 +: 4] > 4'h4) d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
         end
         d = {d[38:0], b[i]};
      end
      return d;
   endfunction : to_bcd

   ////////////////////////////////////////////////////////////////////////////
   // Whole-block next state
   always_comb begin
      srcp_line_t lc;
      logic [3:0] nd, L, nw;
      logic [2:0] nv;
      logic [31:0] v, mag;
      logic [39:0] bcd;
      logic [3:0] k;
      logic par, neg, mine;
      logic [15:0] wd;
      lc = srcp_line_t'(s.ctrl[C_TWO:C_PAR]);
      nd = lc.eight ? 4'h8 : 4'h7;
      L = s.fmt[3:0];
      nv = s.fmt[6:4];
      nw = s.fmt[F_DWORD] ? 4'({nv, 1'b0}) : 4'(nv);
      v = s.val[s.vi[1:0]];
      neg = v[31];
      mag = neg ? 32'(-v) : v;
      bcd = to_bcd(mag);
      k = L - 4'h1 - s.ci;
      par = 1'b0;
      mine = 1'b0;
      wd = '0;
      n = s;
      n.insp_p = '0;
      n.save_p = 1'b0;
      ch_v = 1'b0;
      ch = CH_CR;
      rx_got = 1'b0;
      rx_ch = '0;

      // Receiver: pin passes two flops before use
      n.rx_s1 = rxd;
      n.rx_s2 = s.rx_s1;
      if (!s.rx_busy) begin
         if (!s.rx_s2) begin
            n.rx_busy = 1'b1;
            n.rx_cnt = {1'b0, s.baud[15:1]};
            n.rx_bit = '0;
         end
      end else if (s.rx_cnt != 16'h0000) begin
         n.rx_cnt = s.rx_cnt - 16'h0001;
      end else begin
         n.rx_cnt = s.baud[15:0] - 16'h0001;
         n.rx_bit = s.rx_bit + 4'h1;
         if (s.rx_bit == 4'h0) begin
            n.rx_busy = !s.rx_s2;
         end else begin
            n.rx_sh[s.rx_bit - 4'h1] = s.rx_s2;
            // Stop bit sampled: check framing and parity, then deliver
            if (s.rx_bit == nd + 4'((lc.parity != PAR_NONE)) + 4'h1) begin
               n.rx_busy = 1'b0;
               rx_ch = lc.eight ? n.rx_sh[7:0] : {1'b0, n.rx_sh[6:0]};
               par = ^rx_ch ^ n.rx_sh[nd] ^ (lc.parity == PAR_ODD);
               rx_got = s.rx_s2 && (lc.parity == PAR_NONE || !par);
            end
         end
      end

      // Command assembly; carriage return closes a command
      if (rx_got && s.st != ST_PACK) begin
         if (rx_ch == CH_CR) begin
            n.cmd_rdy = 1'b1;
         end else if (!s.cmd_rdy && s.cmd_n != 4'hF) begin
            n.cmd = {s.cmd[7:0], rx_ch};
            n.cmd_n = s.cmd_n + 4'h1;
         end
      end

      // Character source; one sequencer owns the transmitter
      case (s.st)
         ST_IDLE: begin
            if (s.go_pend) begin
               // Pending output has priority over slave commands
               n.st = s.ctrl[C_PUSH] ? ST_PUSH : ST_RESULT;
               n.pfx = 1'b0;
               n.phase = 2'h1;
               n.vi = '0;
               n.ci = '0;
               n.fi = 4'hF;
               n.wi = '0;
               n.bi = '0;
            end else if (s.cmd_rdy) begin
               // Slave behaviour while nothing is pending
               n.cmd_rdy = 1'b0;
               n.cmd_n = '0;
               n.st = ST_REPLY;
               n.rep_i = '0;
               n.rep_n = 2'h2;
               n.rep = {s.cmd, 8'h00};
               if (s.cmd_n != 4'h2) begin
                  n.rep = ERR_FORM;
                  n.rep_n = 2'h3;
               end else begin
                  case (s.cmd)
                     CMD_T1, CMD_T2: mine = s.run;
                     CMD_PG, CMD_TO, CMD_TF: mine = s.run;
                     CMD_RN, CMD_SV: mine = !s.run;
                     default: begin
                        n.rep = ERR_FORM;
                        n.rep_n = 2'h3;
                     end
                  endcase
                  if (n.rep_n == 2'h2 && !mine) begin
                     n.rep = ERR_PERM;
                     n.rep_n = 2'h3;
                  end
                  // Actions take effect before the echo leaves
                  if (mine) begin
                     case (s.cmd)
                        CMD_T1: n.src = 2'h1;
                        CMD_T2: n.src = 2'h2;
                        CMD_PG: n.run = 1'b0;
                        CMD_RN: n.run = 1'b1;
                        CMD_TO: n.trig_en = 1'b1;
                        CMD_TF: n.trig_en = 1'b0;
                        CMD_SV: n.save_p = 1'b1;
                        default: n.src = '0;
                     endcase
                  end
               end
            end
         end
         ST_REPLY: begin
            ch_v = 1'b1;
            // Index rep_n hands over the closing carriage return
            if (s.rep_i != {1'b0, s.rep_n}) ch = s.rep[23 - 8*s.rep_i -: 8];
            else ch = CH_CR;
            if (!s.tx_busy && s.rep_i == {1'b0, s.rep_n} + 3'h1) begin
               // Inspection starts only once the echo is out
               n.st = (s.src != 2'h0) ? ST_INSP : ST_IDLE;
               n.insp_p = s.src;
            end
         end
         ST_INSP: begin
            if (insp_done) begin
               n.st = ST_RESULT;
               n.src = '0;
               n.pfx = 1'b1;
               n.phase = 2'h0;
               n.vi = '0;
               n.ci = '0;
               n.fi = 4'hF;
            end
         end
         ST_RESULT: begin
            ch_v = 1'b1;
            case (s.phase)
               2'h0: ch = s.ci[0] ? PFX_RES[7:0] : PFX_RES[15:8];
               2'h1: begin
                  if (nv == 3'h0) ch_v = 1'b0;
                  else if (neg && s.ci == 4'h0) ch = CH_MINUS;
                  else if (k < 4'hA) ch = CH_ZERO | {4'h0, bcd[k*4 +: 4]};
                  else ch = CH_ZERO;
               end
               2'h2: begin
                  ch_v = s.jsel[s.fi];
                  ch = CH_ZERO | {7'h00, s.jres[s.fi]};
               end
               default: ch = CH_CR;
            endcase
         end
         ST_PUSH: begin
            ch_v = 1'b1;
            // Word wi goes to register start+wi; last record is the flag
            if (s.wi == nw) begin
               n.rep[15:0] = s.pcfg[31:16];
               wd = DONE_VAL;
            end else begin
               n.rep[15:0] = s.pcfg[15:0] + 16'(s.wi);
               if (s.fmt[F_DWORD]) wd = s.wi[0] ? s.val[s.wi[2:1]][31:16]
                                               : s.val[s.wi[2:1]][15:0];
               else wd = s.val[s.wi[1:0]][15:0];
            end
            case (s.bi)
               2'h0: ch = n.rep[15:8];
               2'h1: ch = n.rep[7:0];
               2'h2: ch = wd[15:8];
               default: ch = wd[7:0];
            endcase
         end
         ST_PACK: begin
            if (rx_got) begin
               n.wi = s.wi + 4'h1;
               n.st = (s.wi == nw) ? ST_IDLE : ST_PUSH;
               n.go_pend = s.wi != nw;
            end else if (s.tcnt == 32'h0) begin
               n.tout_err = 1'b1;
               n.st = ST_IDLE;
               n.go_pend = 1'b0;
            end else begin
               n.tcnt = s.tcnt - 32'h1;
            end
         end
         default: n.st = ST_IDLE;
      endcase

      // Sequencer advance on each character handed over
      take = ch_v && !s.tx_busy && !(s.st == ST_REPLY && s.rep_i == {1'b0, s.rep_n} + 3'h1);
      if (s.st == ST_REPLY && take) n.rep_i = s.rep_i + 3'h1;
      if (s.st == ST_RESULT && (take || !ch_v)) begin
         case (s.phase)
            2'h0: begin
               n.ci = s.ci + 4'h1;
               if (s.ci == 4'h1) begin
                  n.phase = 2'h1;
                  n.ci = '0;
               end
            end
            2'h1: begin
               n.ci = s.ci + 4'h1;
               if (nv == 3'h0 || (s.ci == L - 4'h1 && s.vi == nv - 3'h1)) begin
                  n.phase = 2'h2;
                  n.ci = '0;
               end else if (s.ci == L - 4'h1) begin
                  n.ci = '0;
                  n.vi = s.vi + 3'h1;
               end
            end
            2'h2: begin
               n.fi = s.fi - 4'h1;
               if (s.fi == 4'h0) n.phase = 2'h3;
            end
            default: begin
               n.st = ST_IDLE;
               n.go_pend = s.pfx ? s.go_pend : 1'b0;
            end
         endcase
      end
      if (s.st == ST_PUSH && take) begin
         n.bi = s.bi + 2'h1;
         if (s.bi == 2'h3) begin
            n.st = ST_PACK;
            n.tcnt = s.tout;
         end
      end

      // Transmitter: frame built LSB first, idle register is all ones
      if (take) begin
         n.tx_sh = '1;
         n.tx_sh[0] = 1'b0;
         for (int i = 0; i < 8; i++) begin
            if (4'(i) < nd) n.tx_sh[i + 1] = ch[i];
         end
         if (lc.parity != PAR_NONE) begin
            n.tx_sh[nd + 4'h1] = ^(lc.eight ? ch : {1'b0, ch[6:0]})
                                  ^ (lc.parity == PAR_ODD);
         end
         n.tx_nb = nd + 4'h2 + 4'((lc.parity != PAR_NONE)) + 4'(lc.two_stop);
         n.tx_busy = 1'b1;
         n.tx_bit = '0;
         n.tx_cnt = s.baud[15:0] - 16'h0001;
      end else if (s.tx_busy) begin
         n.tx_cnt = s.tx_cnt - 16'h0001;
         if (s.tx_cnt == 16'h0000) begin
            n.tx_cnt = s.baud[15:0] - 16'h0001;
            n.tx_sh = {1'b1, s.tx_sh[11:1]};
            n.tx_bit = s.tx_bit + 4'h1;
            n.tx_busy = s.tx_bit != s.tx_nb - 4'h1;
         end
      end

      // APB: read data latched in setup, writes in access phase
      if (psel && !penable) begin
         case (paddr)
            A_CTRL: n.prd = s.ctrl;
            A_BAUD: n.prd = s.baud;
            A_FMT: n.prd = s.fmt;
            A_JSEL: n.prd = s.jsel;
            A_JRES: n.prd = s.jres;
            A_PUSH: n.prd = s.pcfg;
            A_TOUT: n.prd = s.tout;
            A_STAT: n.prd = {22'h000000, s.st, 1'b0, s.tout_err, s.trig_en, s.run};
            A_GO: n.prd = {31'h0, s.go_pend};
            default: n.prd = (paddr >= A_VAL && paddr <= A_VAL_END) ?
                             s.val[paddr[3:2]] : 32'h0;
         endcase
      end
      if (psel && penable && pwrite) begin
         case (paddr)
            A_CTRL: n.ctrl = pwdata;
            A_BAUD: n.baud = {16'h0000, pwdata[15:0]};
            A_FMT: n.fmt = pwdata;
            A_JSEL: n.jsel = pwdata;
            A_JRES: n.jres = pwdata;
            A_PUSH: n.pcfg = pwdata;
            A_TOUT: n.tout = pwdata;
            A_STAT: n.tout_err = n.tout_err & ~(pwdata[S_TOUT] & !(s.tcnt == 32'h0
                                 && s.st == ST_PACK && !rx_got));
            A_GO: n.go_pend = n.go_pend | pwdata[0];
            default: if (paddr >= A_VAL && paddr <= A_VAL_END) n.val[paddr[3:2]] = pwdata;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; sync reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '0;
         s.st <= ST_IDLE;
         s.ctrl <= CTRL_RST;
         s.baud <= {16'h0000, BAUD_DIV_DEF};
         s.fmt <= FMT_RST;
         s.pcfg <= PUSH_RST;
         s.tout <= TOUT_RST;
         s.run <= 1'b1;
         s.trig_en <= 1'b1;
         s.tx_sh <= '1;
         s.rx_s1 <= 1'b1;
         s.rx_s2 <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // Outputs
   assign txd = s.tx_sh[0];
   assign prdata = s.prd;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(paddr <= A_GO || (paddr >= A_VAL && paddr <= A_VAL_END))
                    || psel && penable && paddr[1:0] != 2'h0;
   assign insp_req = s.insp_p;
   assign save_req = s.save_p;
   assign run_state = s.run;
   assign trig_enable = s.trig_en;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_BAUD_RESET: assert property ($past(rst) |-> s.baud[15:0] == BAUD_DIV_DEF)
      else $error("baud divisor not at default after reset");
   AST_OWNER: assert property ($rose(s.st == ST_PUSH) |-> $past(s.ctrl[C_PUSH]))
      else $error("push started without push mode");
   AST_SLAVE: assert property (s.st == ST_IDLE && !s.go_pend && s.cmd_rdy
      |=> s.st == ST_REPLY && !s.cmd_rdy)
      else $error("idle port ignored a command");
   AST_INSP_DONE: assert property (s.st == ST_INSP && !insp_done |=> s.st == ST_INSP)
      else $error("result line before inspection done");
   AST_PERM: assert property (s.st == ST_IDLE && !s.go_pend && s.cmd_rdy
      && s.cmd_n == 4'h2 && s.cmd == CMD_PG && !s.run |=> s.rep == ERR_PERM && !s.run)
      else $error("program command not refused");
   AST_FORM: assert property (s.st == ST_IDLE && !s.go_pend && s.cmd_rdy
      && s.cmd_n != 4'h2 |=> s.rep == ERR_FORM ##1 s.st == ST_REPLY)
      else $error("bad length not refused");
   AST_RUN: assert property (s.st == ST_IDLE && !s.go_pend && s.cmd_rdy
      && s.cmd_n == 4'h2 && s.cmd == CMD_RN && !s.run |=> s.run && s.rep[23:8] == CMD_RN)
      else $error("run command not executed");
   AST_NO_MIX: assert property (s.st != ST_IDLE |=> s.run == $past(s.run))
      else $error("command executed during output");
   AST_DONE_ONE: assert property (s.st == ST_PUSH && s.bi == 2'h3 && take
      && s.wi == (s.fmt[F_DWORD] ? 4'({s.fmt[6:4], 1'b0}) : 4'(s.fmt[6:4]))
      |-> ch == DONE_VAL[7:0])
      else $error("completion value wrong");
   AST_TIMEOUT: assert property (s.st == ST_PACK && s.tcnt == 32'h0 && !rx_got
      |=> s.tout_err && s.st == ST_IDLE)
      else $error("timeout not flagged");
   COV_T1: cover property (s.st == ST_INSP ##[1:1000] s.st == ST_RESULT);
   COV_PUSH: cover property (s.st == ST_PACK ##1 s.st == ST_IDLE && !s.tout_err);
   COV_ERR: cover property (s.st == ST_REPLY && s.rep == ERR_PERM);
endmodule : srcp_port

// ---- tb/srcp_host.sv ----
////////////////////////////////////////////////////////////////////////////////
// Host at the far end of the serial line: 7 data bits, even parity, one stop
module srcp_host #(
   parameter int BIT_CYC = 16
) (
   input wire logic ref_clk,
   input wire logic dut_txd,
   output logic dut_rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rx_q[$];
   initial dut_rxd = 1'b1;
   // Frame goes out LSB first; line rests high between frames like a pull-up
   task automatic send_char(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, ^c[6:0], c[6:0], 1'b0};
      for (int i = 0; i < 10; i++) begin
         dut_rxd <= f[i];
         repeat (BIT_CYC) @(posedge ref_clk);
      end
   endtask : send_char
   // Command body then the terminator
   task automatic send_str(input string s);
      for (int i = 0; i < s.len(); i++) send_char(s[i]);
      send_char(8'h0D);
   endtask : send_str
   // Receiver samples mid-bit; a bad frame queues 0xFF so it cannot match
   always begin : rx_proc
      logic [8:0] b;
      @(negedge dut_txd);
      repeat (BIT_CYC / 2) @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT_CYC) @(posedge ref_clk);
         b[i] = dut_txd;
      end
      if (dut_txd === 1'b1 && (^b[7:0]) === 1'b0) begin
         rx_q.push_back({1'b0, b[6:0]});
      end else begin
         rx_q.push_back(8'hFF);
      end
   end
endmodule : srcp_host

// ---- tb/serial_result_and_command_port_test.sv ----
////////////////////////////////////////////////////////////////////////////////
module serial_result_and_command_port_test;
   import srcp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic insp_done = 1'b0, pready, pslverr, rxd, txd, save_req, run_state, trig_enable;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0] insp_req, seen_req = 2'b00;
   logic err;
   int error_cnt = 0, check_count = 0, saves = 0;
   srcp_port #(.TOUT_RST(32'd200)) u_dut (.ref_clk(ref_clk), .rst(rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .insp_req(insp_req),
      .insp_done(insp_done), .save_req(save_req), .run_state(run_state),
      .trig_enable(trig_enable));
   srcp_host #(.BIT_CYC(16)) u_host (.ref_clk(ref_clk), .dut_txd(txd), .dut_rxd(rxd));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // Inspection stand-in answers one cycle after any request
   always @(posedge ref_clk) begin
      insp_done <= |insp_req;
      seen_req <= seen_req | insp_req;
      if (save_req === 1'b1) saves++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // One APB transfer; waits for pready, no assumed latency
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle cycle so a following call never reassigns psel in the same step
      @(posedge ref_clk);
   endtask : apb
   // Each character is awaited under a bound, then compared
   task automatic expect_char(input logic [7:0] e);
      logic [7:0] c;
      for (int t = 0; t < 4000 && u_host.rx_q.size() == 0; t++) @(posedge ref_clk);
      c = (u_host.rx_q.size() > 0) ? u_host.rx_q.pop_front() : 8'hEE;
      cmp("reply char", 32'(e), 32'(c));
   endtask : expect_char
   task automatic expect_line(input string s);
      for (int i = 0; i < s.len(); i++) expect_char(s[i]);
      expect_char(CH_CR);
   endtask : expect_line
   // One pushed record: register number then data word, high bytes first
   task automatic expect_rec(input logic [31:0] r);
      for (int i = 3; i >= 0; i--) expect_char(r[i*8 +: 8]);
   endtask : expect_rec
   task automatic cmd(input string s, input string r);
      u_host.send_str(s);
      expect_line(r);
   endtask : cmd
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (60000) @(posedge ref_clk);
      error_cnt++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      apb(1'b0, A_CTRL, 32'h0);
      cmp("ctrl reset", CTRL_RST, rd);
      apb(1'b0, A_BAUD, 32'h0);
      cmp("baud reset", 32'(BAUD_DIV_DEF), rd);
      apb(1'b0, 8'h40, 32'h0);
      cmp("unmapped err", 32'h1, 32'(err));
      cmp("run reset", 32'h1, 32'(run_state));
      apb(1'b1, A_BAUD, 32'h0000_0010);
      apb(1'b1, A_FMT, 32'h0000_0025);
      apb(1'b1, A_VAL, 32'h0000_04D2);
      apb(1'b1, A_VAL + 8'h04, 32'hFFFF_FFD3);
      apb(1'b1, A_JSEL, 32'h0000_B000);
      apb(1'b1, A_JRES, 32'h0000_1000);
      cmd("T1", "T1");
      expect_line("T001234-0045001");
      cmp("source one", 32'h1, 32'(seen_req));
      cmd("T2", "T2");
      expect_line("T001234-0045001");
      cmp("source two", 32'h3, 32'(seen_req));
      cmd("SV", "E01");
      cmd("TF", "TF");
      cmp("trig off", 32'h0, 32'(trig_enable));
      cmd("TO", "TO");
      cmp("trig on", 32'h1, 32'(trig_enable));
      cmd("PG", "PG");
      cmp("prog state", 32'h0, 32'(run_state));
      cmd("PG", "E01");
      cmd("T1", "E01");
      cmd("SV", "SV");
      cmp("save pulses", 32'h1, 32'(saves));
      cmd("RN", "RN");
      cmp("run again", 32'h1, 32'(run_state));
      cmd("RN", "E01");
      cmd("ABC", "E02");
      cmd("T", "E02");
      cmd("XY", "E02");
      apb(1'b1, A_GO, 32'h0000_0001);
      expect_line("01234-0045001");
      cmd("PG", "PG");
      // Register push: 16-bit words, values kept inside 7-bit frames
      apb(1'b1, A_TOUT, 32'h0000_03E8);
      apb(1'b1, A_FMT, 32'h0000_0015);
      apb(1'b1, A_PUSH, 32'h0020_0010);
      apb(1'b1, A_VAL, 32'h0000_0042);
      apb(1'b1, A_CTRL, CTRL_RST | 32'h0000_0001);
      apb(1'b1, A_GO, 32'h0000_0001);
      expect_rec(32'h0010_0042);
      u_host.send_char(8'h06);
      expect_rec(32'h0020_0001);
      u_host.send_char(8'h06);
      apb(1'b0, A_STAT, 32'h0);
      cmp("no timeout", 32'h0, 32'(rd[S_TOUT]));
      apb(1'b0, A_GO, 32'h0);
      cmp("push done", 32'h0, rd);
      // No acknowledge: the push aborts and flags the timeout
      apb(1'b1, A_GO, 32'h0000_0001);
      expect_rec(32'h0010_0042);
      repeat (1200) @(posedge ref_clk);
      apb(1'b0, A_STAT, 32'h0);
      cmp("timeout flag", 32'h1, 32'(rd[S_TOUT]));
      apb(1'b0, A_GO, 32'h0);
      cmp("push aborted", 32'h0, rd);
      apb(1'b1, A_STAT, 32'h0000_0004);
      apb(1'b0, A_STAT, 32'h0);
      cmp("timeout cleared", 32'h0, 32'(rd[S_TOUT]));
      print_verdict();
   end
endmodule : serial_result_and_command_port_test
